// ### logic/cpbc_pkg.sv
// package: constants and types for the coprocessor bus cycle engine
// Summary of operation
// [RULE1] reg-to-coproc cycle: row strobe, special line high
// [RULE2] register transfers move one or two words
// [RULE3] mem-to-coproc: init cycle then memory cycle
// [RULE4] init cycle drives id, instruction, status code
// [RULE5] coprocessor may return status during init cycle
// [RULE6] address phase drives address plus status code
// [RULE7] immediate count form moves 1 to 32 words
// [RULE8] other form takes count from a register
// [RULE9] index register post-increments or pre-decrements
// [RULE10] coproc-to-mem count from instruction, inc or dec
// [RULE11] coproc-to-mem has one dead bus cycle
// [RULE12] address latch strobe high during data phase
// [RULE13] coprocessor may drive status after transfer
// [RULE14] all cycles 32-bit, half-width select high
// [RULE15] internal command moves no operands, status back
// [RULE16] coprocessor drives bus only in its slots
package cpbc_pkg;
  // -------------------------------------------------------------
  // cycle kinds and states
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    CPBC_OP_TO_CP,
    CPBC_OP_FROM_CP,
    CPBC_OP_MEM_TO_CP,
    CPBC_OP_CP_TO_MEM,
    CPBC_OP_INTERNAL
  } cpbc_op_t;

  typedef enum logic [3:0] {
    CPBC_ST_IDLE,
    CPBC_ST_CMD,
    CPBC_ST_CMD_STAT,
    CPBC_ST_REG_DATA,
    CPBC_ST_ADDR,
    CPBC_ST_DEAD,
    CPBC_ST_MEM_DATA,
    CPBC_ST_TAIL_STAT
  } cpbc_state_t;

  // -------------------------------------------------------------
  // sizes, status codes, reset values
  // -------------------------------------------------------------
  localparam int          CPBC_DW        = 32;
  localparam int          CPBC_CNT_W     = 6;
  localparam logic [5:0]  CPBC_CNT_MAX   = 6'h20;
  localparam logic [31:0] CPBC_WORD_STEP = 32'h0000_0020;
  localparam logic [3:0]  CPBC_STAT_CMD  = 4'h9;
  localparam logic [3:0]  CPBC_STAT_ADDR = 4'ha;
  localparam int          CPBC_STAT_LSB  = 0;
  localparam int          CPBC_QTR       = 4;
  localparam logic [1:0]  CPBC_QTR_LAST  = 2'h3;
  localparam logic [31:0] CPBC_RST_WORD  = 32'h0000_0000;
endpackage : cpbc_pkg

// ### logic/cpbc_buf_if.sv
// interface: valid/ready word stream between engine and buffer
`timescale 1ns/1ps
interface cpbc_buf_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cpbc_buf_if

// ### logic/cpbc_buf2.sv
// two-entry valid/ready buffer for words read from the coprocessor
`timescale 1ns/1ps
module cpbc_buf2 (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  cpbc_buf_if.snk   in_s,
  cpbc_buf_if.src   out_s
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  logic [31:0] mem_r [2];
  logic        wp_r;
  logic        rp_r;
  logic [1:0]  cnt_r;
  wire         push = in_s.valid && in_s.ready;
  wire         pop  = out_s.valid && out_s.ready;

  assign in_s.ready  = (cnt_r != 2'h2);
  assign out_s.valid = (cnt_r != 2'h0);
  assign out_s.data  = mem_r[rp_r];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_r[0] <= cpbc_pkg::CPBC_RST_WORD;
      mem_r[1] <= cpbc_pkg::CPBC_RST_WORD;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_s.data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // a stalled reader must see the same word again, never a newer one
  AST_BUF_HOLD: assert property ( // [RULE2]
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("buffered word lost while stalled");
endmodule : cpbc_buf2

// ### logic/cpbc_engine.sv
// coprocessor bus cycle engine: drives the shared local bus
`timescale 1ns/1ps
module cpbc_engine (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // request from the instruction side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [2:0]  req_op,
  input  wire logic [2:0]  req_cp_id,
  input  wire logic [24:0] req_instr,
  input  wire logic        req_two,
  input  wire logic        req_cnt_from_reg,
  input  wire logic [5:0]  req_cnt_imm,
  input  wire logic [5:0]  req_cnt_reg,
  input  wire logic        req_predec,
  input  wire logic [31:0] req_index,
  input  wire logic [31:0] req_wdata0,
  input  wire logic [31:0] req_wdata1,
  // results
  output logic             done,
  output logic [31:0]      index_out,
  output logic [31:0]      cp_status,
  output logic             cp_status_vld,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [31:0]      rd_data,
  // local bus pins
  input  wire logic [31:0] local_addr_data_bus_i,
  output logic [31:0]      local_addr_data_bus_o,
  output logic             local_addr_data_bus_oe,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             special_function_line,
  output logic             addr_latch_strobe,
  output logic             half_width_select
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // quarter-cycle divider: one bus slot per four clocks
  // ---------------------------------------------------------------
  logic [1:0] qtr_r;
  wire        slot_end = (qtr_r == cpbc_pkg::CPBC_QTR_LAST);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      qtr_r <= 2'h0;
    else
      qtr_r <= qtr_r + 2'h1;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cpbc_pkg::cpbc_state_t st_r, st_nxt;
  cpbc_pkg::cpbc_op_t    op_r;
  logic [31:0] cmd_r;
  logic [31:0] idx_r;
  logic [31:0] wd_r [2];
  logic [5:0]  left_r;
  logic        dec_r;
  logic        wsel_r;
  logic        stall;

  cpbc_buf_if rd_in ();
  cpbc_buf_if rd_out ();

  cpbc_buf2 u_buf (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .in_s    (rd_in.snk),
    .out_s   (rd_out.src)
  );

  assign rd_valid     = rd_out.valid;
  assign rd_data      = rd_out.data;
  assign rd_out.ready = rd_ready;

  function automatic logic [5:0] clip_cnt(input logic [5:0] c);
    clip_cnt = (c == 6'h0 || c > cpbc_pkg::CPBC_CNT_MAX)
               ? cpbc_pkg::CPBC_CNT_MAX : c;
  endfunction : clip_cnt

  wire is_cmd   = (st_r == cpbc_pkg::CPBC_ST_CMD);
  wire is_addr  = (st_r == cpbc_pkg::CPBC_ST_ADDR);
  wire is_mdat  = (st_r == cpbc_pkg::CPBC_ST_MEM_DATA);
  wire is_rdat  = (st_r == cpbc_pkg::CPBC_ST_REG_DATA);
  wire cp_drv   = (op_r == cpbc_pkg::CPBC_OP_FROM_CP) ||
                  (op_r == cpbc_pkg::CPBC_OP_CP_TO_MEM);
  wire rd_slot  = (is_rdat || is_mdat) && cp_drv;
  // a word from the coprocessor is captured only when the buffer has room
  assign stall       = rd_slot && !rd_in.ready;
  assign rd_in.valid = rd_slot && slot_end;
  assign rd_in.data  = local_addr_data_bus_i;
  wire last_word     = (left_r == 6'h1);
  wire step          = slot_end && !stall;
  wire [31:0] idx_dn = idx_r - cpbc_pkg::CPBC_WORD_STEP;
  wire [31:0] idx_up = idx_r + cpbc_pkg::CPBC_WORD_STEP;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      cpbc_pkg::CPBC_ST_IDLE:
        if (req_valid) st_nxt = cpbc_pkg::CPBC_ST_CMD;
      cpbc_pkg::CPBC_ST_CMD:
        st_nxt = cpbc_pkg::CPBC_ST_CMD_STAT;                  // [RULE4]
      cpbc_pkg::CPBC_ST_CMD_STAT: begin
        unique case (op_r)
          cpbc_pkg::CPBC_OP_INTERNAL:
            st_nxt = cpbc_pkg::CPBC_ST_IDLE;                  // [RULE15]
          cpbc_pkg::CPBC_OP_MEM_TO_CP,
          cpbc_pkg::CPBC_OP_CP_TO_MEM:
            st_nxt = cpbc_pkg::CPBC_ST_ADDR;                  // [RULE3]
          default:
            st_nxt = cpbc_pkg::CPBC_ST_REG_DATA;
        endcase
      end
      cpbc_pkg::CPBC_ST_REG_DATA:
        if (last_word) st_nxt = cpbc_pkg::CPBC_ST_IDLE;      // [RULE2]
      cpbc_pkg::CPBC_ST_ADDR:
        st_nxt = (op_r == cpbc_pkg::CPBC_OP_CP_TO_MEM)
                 ? cpbc_pkg::CPBC_ST_DEAD                     // [RULE11]
                 : cpbc_pkg::CPBC_ST_MEM_DATA;
      cpbc_pkg::CPBC_ST_DEAD:
        st_nxt = cpbc_pkg::CPBC_ST_MEM_DATA;
      cpbc_pkg::CPBC_ST_MEM_DATA:
        if (last_word)
          st_nxt = (op_r == cpbc_pkg::CPBC_OP_CP_TO_MEM)
                   ? cpbc_pkg::CPBC_ST_TAIL_STAT              // [RULE13]
                   : cpbc_pkg::CPBC_ST_IDLE;
      cpbc_pkg::CPBC_ST_TAIL_STAT:
        st_nxt = cpbc_pkg::CPBC_ST_IDLE;
      default:
        st_nxt = cpbc_pkg::CPBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      st_r <= cpbc_pkg::CPBC_ST_IDLE;
    else if (step)
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // command capture, count and index
  // ---------------------------------------------------------------
  wire take = step && (st_r == cpbc_pkg::CPBC_ST_IDLE) && req_valid;
  assign req_ready = slot_end && (st_r == cpbc_pkg::CPBC_ST_IDLE);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_r     <= cpbc_pkg::CPBC_OP_INTERNAL;
      cmd_r    <= cpbc_pkg::CPBC_RST_WORD;
      idx_r    <= cpbc_pkg::CPBC_RST_WORD;
      wd_r[0]  <= cpbc_pkg::CPBC_RST_WORD;
      wd_r[1]  <= cpbc_pkg::CPBC_RST_WORD;
      left_r   <= 6'h0;
      dec_r    <= 1'b0;
      wsel_r   <= 1'b0;
    end else if (take) begin
      op_r    <= cpbc_pkg::cpbc_op_t'(req_op);
      cmd_r   <= {req_cp_id, req_instr, cpbc_pkg::CPBC_STAT_CMD}; // [RULE4]
      idx_r   <= req_index;
      wd_r[0] <= req_wdata0;
      wd_r[1] <= req_wdata1;
      dec_r   <= req_predec;
      wsel_r  <= 1'b0;
      if (req_op == 3'(cpbc_pkg::CPBC_OP_TO_CP) ||
          req_op == 3'(cpbc_pkg::CPBC_OP_FROM_CP))
        left_r <= req_two ? 6'h2 : 6'h1;                      // [RULE2]
      else if (req_op == 3'(cpbc_pkg::CPBC_OP_MEM_TO_CP) &&
               req_cnt_from_reg)
        left_r <= clip_cnt(req_cnt_reg);                      // [RULE8]
      else
        left_r <= clip_cnt(req_cnt_imm);                  // [RULE7] [RULE10]
    end else if (step) begin
      if (is_addr && dec_r)
        idx_r <= idx_dn;                                      // [RULE9]
      if (is_mdat || is_rdat) begin
        left_r <= left_r - 6'h1;
        wsel_r <= 1'b1;
      end
      if (is_mdat && !last_word)
        idx_r <= dec_r ? idx_dn : idx_up;                 // [RULE9] [RULE10]
      if (is_mdat && last_word && !dec_r)
        idx_r <= idx_up;
    end
  end

  // ---------------------------------------------------------------
  // status back from the coprocessor and completion
  // ---------------------------------------------------------------
  wire stat_slot = slot_end && (st_r == cpbc_pkg::CPBC_ST_CMD_STAT ||
                   st_r == cpbc_pkg::CPBC_ST_TAIL_STAT);  // [RULE5] [RULE13]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cp_status     <= cpbc_pkg::CPBC_RST_WORD;
      cp_status_vld <= 1'b0;
      done          <= 1'b0;
    end else begin
      cp_status_vld <= stat_slot;
      if (stat_slot)
        cp_status <= local_addr_data_bus_i;
      done      <= step && (st_r != cpbc_pkg::CPBC_ST_IDLE) &&
                   (st_nxt == cpbc_pkg::CPBC_ST_IDLE);
    end
  end

  // the index flop itself is the output, so it is final when done rises
  assign index_out = idx_r;

  // ---------------------------------------------------------------
  // bus pins
  // ---------------------------------------------------------------
  wire dev_drv = is_cmd || is_addr ||
                 ((is_rdat || is_mdat) && op_r == cpbc_pkg::CPBC_OP_TO_CP);
  wire busy    = (st_r != cpbc_pkg::CPBC_ST_IDLE);
  wire mem_cyc = is_addr || is_mdat || (st_r == cpbc_pkg::CPBC_ST_DEAD);
  // a pre-decrement puts the already stepped address on the bus
  wire [31:0] addr_word = dec_r ? idx_dn : idx_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      local_addr_data_bus_o  <= cpbc_pkg::CPBC_RST_WORD;
      local_addr_data_bus_oe <= 1'b0;
      ras_n                  <= 1'b1;
      cas_n                  <= 1'b1;
      we_n                   <= 1'b1;
      special_function_line  <= 1'b1;
      addr_latch_strobe      <= 1'b1;
      half_width_select      <= 1'b1;
    end else begin
      local_addr_data_bus_oe <= dev_drv;                      // [RULE11]
      local_addr_data_bus_o  <= is_cmd ? cmd_r :
                                is_addr ? {addr_word[31:4],
                                cpbc_pkg::CPBC_STAT_ADDR} :   // [RULE6]
                                wd_r[wsel_r];
      // memory is touched only in a memory cycle; register cycles keep
      // row strobe and special line high so no DRAM responds
      ras_n                  <= !mem_cyc;                     // [RULE1]
      special_function_line  <= 1'b1;                         // [RULE1]
      cas_n                  <= !is_mdat;
      we_n                   <= !(busy && (op_r == cpbc_pkg::CPBC_OP_TO_CP
                                || op_r == cpbc_pkg::CPBC_OP_CP_TO_MEM));
      addr_latch_strobe      <= !is_addr || is_mdat;          // [RULE12]
      half_width_select      <= 1'b1;                         // [RULE14]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_REG_NO_ROW: assert property ( // [RULE1]
    is_rdat |=> ras_n && special_function_line)
    else $error("row strobe low in register transfer");
  AST_DEAD_RELEASE: assert property ( // [RULE11]
    st_r == cpbc_pkg::CPBC_ST_DEAD |=> !local_addr_data_bus_oe)
    else $error("bus driven in dead cycle");
  AST_LATCH_DATA: assert property ( // [RULE12]
    is_mdat |=> addr_latch_strobe)
    else $error("latch strobe low in data phase");
  AST_FULL_WIDTH: assert property ( // [RULE14]
    busy |=> half_width_select)
    else $error("half width select dropped");
  AST_CMD_DRIVE: assert property ( // [RULE4]
    is_cmd |=> local_addr_data_bus_oe &&
    local_addr_data_bus_o[3:0] == cpbc_pkg::CPBC_STAT_CMD)
    else $error("command slot not driven");
  AST_ADDR_STAT: assert property ( // [RULE6]
    is_addr |=>
    local_addr_data_bus_o[3:0] == cpbc_pkg::CPBC_STAT_ADDR)
    else $error("address slot lacks status code");
  AST_CNT_RANGE: assert property ( // [RULE7]
    busy |-> left_r <= cpbc_pkg::CPBC_CNT_MAX)
    else $error("count above 32");
  AST_INT_SHORT: assert property ( // [RULE15]
    st_r == cpbc_pkg::CPBC_ST_CMD_STAT &&
    op_r == cpbc_pkg::CPBC_OP_INTERNAL && step |=>
    st_r == cpbc_pkg::CPBC_ST_IDLE)
    else $error("internal command moved data");
  AST_REG_TWO: assert property ( // [RULE2]
    is_rdat |-> left_r inside {6'h1, 6'h2})
    else $error("register transfer count wrong");
  AST_MEM_INIT: assert property ( // [RULE3]
    $rose(is_addr) |-> $past(st_r) == cpbc_pkg::CPBC_ST_CMD_STAT)
    else $error("memory cycle without init");

  COV_INTERNAL: cover property (@(posedge clk_sys)
    take && req_op == 3'(cpbc_pkg::CPBC_OP_INTERNAL));
  COV_DEAD: cover property (@(posedge clk_sys)
    st_r == cpbc_pkg::CPBC_ST_DEAD);
  COV_STALL: cover property (@(posedge clk_sys) stall);
  COV_TWO: cover property (@(posedge clk_sys) take && req_two);
endmodule : cpbc_engine

// ### bench/cpbc_cp_model.sv
// coprocessor and local memory model on the shared local bus
`timescale 1ns/1ps
module cpbc_cp_model #(
  parameter logic [31:0] STAT_WORD = 32'h5a00_0c01
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        take,
  input  wire logic [2:0]  op,
  input  wire logic        two,
  input  wire logic        done,
  output logic [31:0]      bus_o
);
  logic [2:0]  op_r;
  logic        two_r, act_r, drv;
  logic [11:0] cnt_r;
  logic [7:0]  seq_r;
  logic [9:0]  slot;
  logic [31:0] word, last_r;
  assign slot = cnt_r[11:2];
  always_comb begin
    drv = 1'b0;
    word = STAT_WORD;
    if (act_r && !done) begin
      if (slot == 10'h1) drv = 1'b1;
      else if (op_r == 3'h1 && slot >= 10'h2) begin
        drv = 1'b1;
        word = {20'hd0000, seq_r, 3'h0, two_r & (slot >= 10'h3)};
      end
      else if (op_r == 3'h2 && slot >= 10'h3) begin
        drv = 1'b1;
        word = {20'hbeef0, slot, 2'h0};
      end
      // dead slot 3 stays released; data, then tail status from slot 4
      else if (op_r == 3'h3 && slot >= 10'h4) drv = 1'b1;
    end
  end
  // a released bus shows the inverse of its last value, never a stale copy
  assign bus_o = drv ? word : ~last_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      act_r <= 1'b0;
      cnt_r <= 12'h0;
      seq_r <= 8'h0;
      op_r <= 3'h0;
      two_r <= 1'b0;
      last_r <= 32'h0;
    end else begin
      if (drv) last_r <= word;
      if (take) begin
        act_r <= 1'b1;
        cnt_r <= 12'h0;
        seq_r <= seq_r + 8'h1;
        op_r <= op;
        two_r <= two;
      end else if (act_r) begin
        cnt_r <= cnt_r + 12'h1;
        if (done) act_r <= 1'b0;
      end
    end
  end
endmodule : cpbc_cp_model

// ### bench/coprocessor_bus_cycles_test.sv
// self-checking bench for the coprocessor bus cycle engine
`timescale 1ns/1ps
module coprocessor_bus_cycles_test;
  localparam logic [31:0] STAT = 32'h5a00_0c01;
  logic        clk_sys, arst_n, req_valid, req_two, req_cfr, req_predec;
  logic        rd_ready, req_ready, done, st_vld, rd_valid, oe, ras_n;
  logic        cas_n, we_n, sfl, als, hws, oe_q;
  logic [2:0]  req_op, req_cp_id;
  logic [24:0] req_instr;
  logic [5:0]  req_cnt_imm, req_cnt_reg;
  logic [31:0] req_index, req_wdata0, req_wdata1, index_out, cp_status;
  logic [31:0] rd_data, bus_o, p_bus, bus_i;
  logic [7:0]  nops;
  int          n_fail, check_count, ras_lo, we_lo, als_lo, oe_rise, n;
  int          cas_lo;
  logic [31:0] seen_q[$];
  assign bus_i = oe ? bus_o : p_bus;
  cpbc_engine i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_cp_id(req_cp_id),
    .req_instr(req_instr), .req_two(req_two), .req_cnt_from_reg(req_cfr),
    .req_cnt_imm(req_cnt_imm), .req_cnt_reg(req_cnt_reg),
    .req_predec(req_predec), .req_index(req_index),
    .req_wdata0(req_wdata0), .req_wdata1(req_wdata1), .done(done),
    .index_out(index_out), .cp_status(cp_status), .cp_status_vld(st_vld),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .local_addr_data_bus_i(bus_i), .local_addr_data_bus_o(bus_o),
    .local_addr_data_bus_oe(oe), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .special_function_line(sfl), .addr_latch_strobe(als),
    .half_width_select(hws));
  cpbc_cp_model #(.STAT_WORD(STAT)) i_cp (
    .clk_sys(clk_sys), .arst_n(arst_n), .take(req_valid & req_ready),
    .op(req_op), .two(req_two), .done(done), .bus_o(p_bus));
  // ---------------------------------------------------------------
  // bus monitor
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (oe && (!oe_q || bus_o !== seen_q[$])) seen_q.push_back(bus_o);
    if (oe && !oe_q) oe_rise++;
    if (!ras_n) ras_lo++;
    if (!we_n) we_lo++;
    if (!als) als_lo++;
    if (!cas_n) cas_lo++;
    oe_q = oe;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic issue(input logic [2:0] op, input logic two,
      input logic cfr, input logic pre, input logic [5:0] cnt,
      input logic [31:0] idx);
    int t;
    @(negedge clk_sys);
    seen_q.delete();
    ras_lo = 0; we_lo = 0; als_lo = 0; oe_rise = 0;
    cas_lo = 0;
    req_op = op; req_two = two; req_cfr = cfr; req_predec = pre;
    req_cnt_imm = cnt; req_index = idx;
    t = 0;
    while (req_ready !== 1'b1 && t < 20) begin
      @(negedge clk_sys);
      t++;
    end
    req_valid = 1'b1;
    nops++;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : issue
  task automatic finish_op(output int k);
    logic [31:0] cw;
    k = 1;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    check({31'h0, done}, 32'h1);
    check(cp_status, STAT);
    check({30'h0, sfl, hws}, 32'h3);
    cw = {req_cp_id, req_instr, cpbc_pkg::CPBC_STAT_CMD};
    check(seen_q[0], cw);
  endtask : finish_op
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_to_cp;
    for (int k = 0; k < 2; k++) begin
      issue(3'h0, k[0], 1'b0, 1'b0, 6'h1, 32'h0);
      finish_op(n);
      check(32'(seen_q.size()), 32'(2 + k));
      check(seen_q[1], req_wdata0);
      if (k == 1) check(seen_q[2], req_wdata1);
      check({31'h0, ras_lo == 0 && we_lo > 0}, 32'h1);
    end
    $display("test to_cp done");
  endtask : t_to_cp
  task automatic t_internal;
    issue(3'h4, 1'b0, 1'b0, 1'b0, 6'h1, 32'h0);
    finish_op(n);
    check(32'(n), 32'h9);
    check(32'(seen_q.size()), 32'h1);
    check({31'h0, st_vld}, 32'h1);
    $display("test internal done");
  endtask : t_internal
  task automatic t_mem_to_cp;
    logic [31:0] ea[2] = '{32'h0001_000a, 32'h0000_ffea};
    logic [31:0] ei[2] = '{32'h0001_0060, 32'h0000_ff60};
    req_cnt_reg = 6'h5;
    for (int k = 0; k < 2; k++) begin
      issue(3'h2, 1'b0, k[0], k[0], 6'h3, 32'h0001_0000);
      finish_op(n);
      check(seen_q[1], ea[k]);
      check(index_out, ei[k]);
    end
    $display("test mem_to_cp done");
  endtask : t_mem_to_cp
  task automatic t_cp_to_mem;
    logic [31:0] ei[2] = '{32'h0002_0400, 32'h0001_ffe0};
    for (int k = 0; k < 2; k++) begin
      issue(3'h3, 1'b0, 1'b0, k[0], 6'(k), 32'h0002_0000);
      finish_op(n);
      check(index_out, ei[k]);
      check(32'(oe_rise), 32'h2);
      check(32'(als_lo), 32'h4);
      check({31'h0, st_vld}, 32'h1);
      check(32'(cas_lo), (k == 0) ? 32'h80 : 32'h4);
    end
    $display("test cp_to_mem done");
  endtask : t_cp_to_mem
  task automatic t_from_cp;
    logic [7:0]  s;
    logic [31:0] got_q[$];
    bit          early;
    int          t;
    rd_ready = 1'b0;
    issue(3'h1, 1'b1, 1'b0, 1'b0, 6'h1, 32'h0);
    s = nops;
    finish_op(n);
    // buffer is full now, so the next read slot has to wait
    issue(3'h1, 1'b0, 1'b0, 1'b0, 6'h1, 32'h0);
    early = 1'b0;
    repeat (60) begin
      @(negedge clk_sys);
      early = early | done;
    end
    check({31'h0, early}, 32'h0);
    rd_ready = 1'b1;
    t = 0;
    while (got_q.size() < 3 && t < 200) begin
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
      @(negedge clk_sys);
      t++;
    end
    rd_ready = 1'b0;
    check(got_q[0], {20'hd0000, s, 4'h0});
    check(got_q[1], {20'hd0000, s, 4'h1});
    check(got_q[2], {20'hd0000, s + 8'h1, 4'h0});
    repeat (20) @(negedge clk_sys);
    check({31'h0, rd_valid}, 32'h0);
    $display("test from_cp done");
  endtask : t_from_cp
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    arst_n = 1'b0; req_valid = 1'b0; req_two = 1'b0; req_cfr = 1'b0;
    req_predec = 1'b0; rd_ready = 1'b1; req_op = 3'h0;
    req_cp_id = 3'h5; req_instr = 25'h1a5_c3e1; req_cnt_imm = 6'h1;
    req_cnt_reg = 6'h1; req_index = 32'h0; oe_q = 1'b0; nops = 8'h0;
    req_wdata0 = 32'h1234_5678; req_wdata1 = 32'h9abc_def0;
    n_fail = 0; check_count = 0;
    repeat (4) @(negedge clk_sys);
    check({26'h0, oe, ras_n, cas_n, we_n, done, rd_valid}, 32'h1c);
    arst_n = 1'b1;
    t_to_cp;
    t_internal;
    t_mem_to_cp;
    t_cp_to_mem;
    t_from_cp;
    tally_and_finish;
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
endmodule : coprocessor_bus_cycles_test
